// file: inc/gac_pkg.sv
// Constants shared by both ends of the gimbal angle coupling link.
// Assumes a single 200 MHz clock on both ends and an APB master on the controller.
// How it works
// - Coarse error steps read counter at 12.8 kpps
// - Fine error steps read counter at 800 pps
// - Ternary error becomes direction plus drive pulses
// - Each read step sends signed angle pulse
// - Commanded pulses accumulate in up/down error counter
// - Read feedback pulses count error counter back
// - Error counter drives magnitude and sign outputs
// - Discretes asserted by pulling line low
// - Zero discrete clears all read counters together
// - Zero discrete holds read counters at zero
// - Controller holds zero discrete 400 ms minimum
// - Enable discrete opens all error counters together
// - Without enable, error counters cleared and blocked
// - Enable alone only for attitude display
// - Coarse align discrete drives coarse relay output
// - Feedback pulses pass only during coarse align
// - Coarse without enable blocks read counter steps
// - Takeover: drop enable, wait half second first
// - Enable 40 ms after takeover, pulses 4 ms later
// - Takeover discrete drives booster steering relay output
// - Coarse align leads enable by 40 ms
// - Coarse pulses 3200 pps, 60 ms bursts, 480 ms apart
package gac_pkg;

  // ---------------------------------------------------------------
  // Clock and widths
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ  = 200_000_000;
  localparam int unsigned AXES    = 3;
  localparam int unsigned RCW     = 16;
  localparam int unsigned ECW     = 12;
  localparam int unsigned TMW     = 32;

  // ---------------------------------------------------------------
  // Device stepping rates
  // ---------------------------------------------------------------
  localparam int unsigned COARSE_PPS      = 12_800;
  localparam int unsigned FINE_PPS        = 800;
  localparam int unsigned COARSE_STEP_CYC = CLK_HZ / COARSE_PPS;
  localparam int unsigned FINE_STEP_CYC   = CLK_HZ / FINE_PPS;

  // ---------------------------------------------------------------
  // Controller timing, times in ms and in clock cycles, pulse rate in pps
  // ---------------------------------------------------------------
  localparam int unsigned ZERO_MIN_MS   = 400;
  localparam int unsigned TO_DROP_MS    = 500;
  localparam int unsigned EC_LEAD_MS    = 40;
  localparam int unsigned EC_SETTLE_MS  = 4;
  localparam int unsigned CMD_PPS       = 3_200;
  localparam int unsigned BURST_ON_MS   = 60;
  localparam int unsigned BURST_PER_MS  = 480;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned ZERO_MIN_CYC  = ZERO_MIN_MS * CYC_PER_MS;
  localparam int unsigned TO_DROP_CYC   = TO_DROP_MS * CYC_PER_MS;
  localparam int unsigned EC_LEAD_CYC   = EC_LEAD_MS * CYC_PER_MS;
  localparam int unsigned EC_SETTLE_CYC = EC_SETTLE_MS * CYC_PER_MS;
  localparam int unsigned CMD_STEP_CYC  = CLK_HZ / CMD_PPS;
  localparam int unsigned BURST_ON_CYC  = BURST_ON_MS * CYC_PER_MS;
  localparam int unsigned BURST_PER_CYC = BURST_PER_MS * CYC_PER_MS;

  // ---------------------------------------------------------------
  // Controller register map (byte addresses) and control bits
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CMD0   = 8'h08;
  localparam logic [7:0] A_ANG0   = 8'h14;
  localparam int unsigned CTRL_ZERO  = 0;
  localparam int unsigned CTRL_CA    = 1;
  localparam int unsigned CTRL_DISP  = 2;
  localparam int unsigned CTRL_TO    = 3;
  localparam logic [3:0] CTRL_RST    = 4'h0;

  typedef enum logic [2:0] {
    S_IDLE, S_DISP, S_CA_LEAD, S_CA_RUN, S_TO_DROP, S_TO_LEAD, S_TO_SETTLE, S_TO_RUN
  } gac_seq_e;

endpackage : gac_pkg

// file: inc/gac_link_if.sv
// Discrete and pulse lines between the controller and the coupling unit.
// Discretes are active low; pulse lines are one-cycle high pulses.
`timescale 1ns/1ps
interface gac_link_if;
  logic       zero_n;
  logic       ec_enable_n;
  logic       coarse_align_n;
  logic       takeover_n;
  logic [2:0] cmd_up;
  logic [2:0] cmd_dn;
  logic [2:0] angle_up;
  logic [2:0] angle_dn;

  modport dev (
    input  zero_n, ec_enable_n, coarse_align_n, takeover_n, cmd_up, cmd_dn,
    output angle_up, angle_dn
  );
  modport host (
    output zero_n, ec_enable_n, coarse_align_n, takeover_n, cmd_up, cmd_dn,
    input  angle_up, angle_dn
  );
endinterface : gac_link_if

// file: rtl/gac_device.sv
// Angle coupling unit: per-axis read counters and error counters with moding.
// Assumes resolver error inputs are synchronous to pclk; link lines are not.
`timescale 1ns/1ps
module gac_device #(
  parameter int unsigned COARSE_CYC = gac_pkg::COARSE_STEP_CYC,
  // Fine period follows the coarse one by the ratio of the two stepping rates
  parameter int unsigned FINE_CYC   = COARSE_CYC * (gac_pkg::COARSE_PPS / gac_pkg::FINE_PPS)
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  gac_link_if.dev                       link,
  input  wire logic [2:0]               res_err_up,
  input  wire logic [2:0]               res_err_dn,
  input  wire logic [2:0]               res_err_coarse,
  output logic [2:0][gac_pkg::RCW-1:0]  read_angle,
  output logic [2:0][gac_pkg::ECW-1:0]  dac_mag,
  output logic [2:0]                    dac_neg,
  output logic                          coarse_relay,
  output logic                          takeover_relay
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic [9:0] prev;
  wire  [9:0] raw = {link.cmd_dn, link.cmd_up, link.takeover_n, link.coarse_align_n,
                     link.ec_enable_n, link.zero_n};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 10'h00F;
      sync2 <= 10'h00F;
      prev  <= 10'h00F;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // Low line means asserted
  wire zero_on = ~sync2[0];
  wire ec_on   = ~sync2[1];
  wire ca_on   = ~sync2[2];
  wire to_on   = ~sync2[3];
  wire [2:0] cmd_up_e = sync2[6:4] & ~prev[6:4];
  wire [2:0] cmd_dn_e = sync2[9:7] & ~prev[9:7];

  // Zero wins; coarse align without enable also freezes the read counters
  wire read_block = zero_on | (ca_on & ~ec_on);

  // ---------------------------------------------------------------
  // Relay drivers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coarse_relay   <= 1'b0;
      takeover_relay <= 1'b0;
    end else begin
      coarse_relay   <= ca_on;
      takeover_relay <= to_on;
    end
  end

  // ---------------------------------------------------------------
  // Per-axis read and error counters
  // ---------------------------------------------------------------
  logic [2:0] ang_up_q;
  logic [2:0] ang_dn_q;
  assign link.angle_up = ang_up_q;
  assign link.angle_dn = ang_dn_q;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic [gac_pkg::TMW-1:0] step_tmr;
      logic signed [gac_pkg::ECW-1:0] err_cnt;
      logic signed [gac_pkg::ECW-1:0] next_err;
      logic [gac_pkg::RCW-1:0] rd_cnt;

      // Ternary error: up, down or none; both set reads as none
      wire dir_up  = res_err_up[g] & ~res_err_dn[g];
      wire dir_dn  = res_err_dn[g] & ~res_err_up[g];
      wire moving  = dir_up | dir_dn;
      wire [gac_pkg::TMW-1:0] period = res_err_coarse[g] ? COARSE_CYC[gac_pkg::TMW-1:0]
                                                         : FINE_CYC[gac_pkg::TMW-1:0];
      wire tick    = moving && (step_tmr >= period - 1'b1);
      wire step_up = tick & dir_up & ~read_block;
      wire step_dn = tick & dir_dn & ~read_block;
      wire fb_up   = step_up & ca_on;
      wire fb_dn   = step_dn & ca_on;

      // Net change of the error counter; opposite requests cancel
      wire signed [2:0] delta = $signed({2'b00, cmd_up_e[g]}) - $signed({2'b00, cmd_dn_e[g]})
                              - $signed({2'b00, fb_up}) + $signed({2'b00, fb_dn});
      wire signed [gac_pkg::ECW-1:0] delta_x = {{(gac_pkg::ECW-3){delta[2]}}, delta};

      always_comb begin
        if (!ec_on) begin
          next_err = '0;
        end else begin
          next_err = err_cnt + delta_x;
        end
      end

      // Timer restarts when there is no error so the first step takes a full period
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          step_tmr <= '0;
        end else if (!moving || tick) begin
          step_tmr <= '0;
        end else begin
          step_tmr <= step_tmr + 1'b1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rd_cnt <= '0;
        end else if (zero_on) begin
          rd_cnt <= '0;
        end else if (step_up) begin
          rd_cnt <= rd_cnt + 1'b1;
        end else if (step_dn) begin
          rd_cnt <= rd_cnt - 1'b1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ang_up_q[g] <= 1'b0;
          ang_dn_q[g] <= 1'b0;
          err_cnt     <= '0;
        end else begin
          ang_up_q[g] <= step_up;
          ang_dn_q[g] <= step_dn;
          err_cnt     <= next_err;
        end
      end

      // Outputs trail the counters by one cycle so they come from flops
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          read_angle[g] <= '0;
          dac_mag[g]    <= '0;
          dac_neg[g]    <= 1'b0;
        end else begin
          read_angle[g] <= rd_cnt;
          dac_mag[g]    <= err_cnt[gac_pkg::ECW-1] ? -err_cnt : err_cnt;
          dac_neg[g]    <= err_cnt[gac_pkg::ECW-1];
        end
      end
    end
  endgenerate

endmodule : gac_device

// file: rtl/gac_host.sv
// Guidance-computer end: APB registers, mode sequencing and pulse sender.
// Assumes an APB master on pclk and the coupling unit on the link interface.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module gac_host #(
  parameter int unsigned ZERO_MIN  = gac_pkg::ZERO_MIN_CYC,
  // Derived waits keep their ratios to the base waits, so one scale sets them all
  parameter int unsigned TO_DROP   = ZERO_MIN / 4 * 5,
  parameter int unsigned EC_LEAD   = gac_pkg::EC_LEAD_CYC,
  parameter int unsigned EC_SETTLE = EC_LEAD / (gac_pkg::EC_LEAD_MS / gac_pkg::EC_SETTLE_MS),
  parameter int unsigned CMD_STEP  = gac_pkg::CMD_STEP_CYC,
  parameter int unsigned BURST_ON  = gac_pkg::BURST_ON_CYC,
  parameter int unsigned BURST_PER = BURST_ON * (gac_pkg::BURST_PER_MS / gac_pkg::BURST_ON_MS)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  gac_link_if.host         link
);

  localparam int unsigned W = gac_pkg::TMW;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [3:0]           ctrl;
  gac_pkg::gac_seq_e    state;
  gac_pkg::gac_seq_e    next_state;
  logic [W-1:0]         seq_tmr;
  logic [W-1:0]         zero_tmr;
  logic [2:0][15:0]     pend;
  logic [2:0][15:0]     angle;
  logic [3:0]           disc;

  wire acc     = psel & penable & ~pready;
  // A write lands at the edge where the master sees pready, not at acceptance
  wire wr      = psel & penable & pready & pwrite;
  wire sel_ctl = paddr == gac_pkg::A_CTRL;
  wire sel_sts = paddr == gac_pkg::A_STATUS;
  wire [7:0] cmd_off = paddr - gac_pkg::A_CMD0;
  wire [7:0] ang_off = paddr - gac_pkg::A_ANG0;
  wire sel_cmd = (paddr >= gac_pkg::A_CMD0) && (paddr < gac_pkg::A_ANG0) && (paddr[1:0] == 2'b00);
  wire sel_ang = (paddr >= gac_pkg::A_ANG0) && (paddr < 8'h20) && (paddr[1:0] == 2'b00);
  wire [1:0] cidx = cmd_off[3:2];
  wire [1:0] aidx = ang_off[3:2];
  wire mapped  = sel_ctl | sel_sts | sel_cmd | sel_ang;
  wire [31:0] rd_mux = sel_ctl ? {28'h0000_000, ctrl}
                     : sel_sts ? {21'h00_0000, state, 4'h0, disc}
                     : sel_cmd ? {16'h0000, pend[cidx]}
                     : sel_ang ? {16'h0000, angle[aidx]}
                     : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= gac_pkg::CTRL_RST;
    end else if (wr && sel_ctl) begin
      ctrl <= pwdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  wire tmr_done = seq_tmr == '0;
  wire ec_used  = (state == gac_pkg::S_DISP) || (state == gac_pkg::S_CA_RUN);

  always_comb begin
    next_state = state;
    case (state)
      gac_pkg::S_TO_DROP:   if (!ctrl[gac_pkg::CTRL_TO]) next_state = gac_pkg::S_IDLE;
                            else if (tmr_done) next_state = gac_pkg::S_TO_LEAD;
      gac_pkg::S_TO_LEAD:   if (!ctrl[gac_pkg::CTRL_TO]) next_state = gac_pkg::S_IDLE;
                            else if (tmr_done) next_state = gac_pkg::S_TO_SETTLE;
      gac_pkg::S_TO_SETTLE: if (!ctrl[gac_pkg::CTRL_TO]) next_state = gac_pkg::S_IDLE;
                            else if (tmr_done) next_state = gac_pkg::S_TO_RUN;
      gac_pkg::S_TO_RUN:    if (!ctrl[gac_pkg::CTRL_TO]) next_state = gac_pkg::S_IDLE;
      gac_pkg::S_CA_LEAD:   if (ctrl[gac_pkg::CTRL_TO]) next_state = gac_pkg::S_TO_LEAD;
                            else if (!ctrl[gac_pkg::CTRL_CA]) next_state = gac_pkg::S_IDLE;
                            else if (tmr_done) next_state = gac_pkg::S_CA_RUN;
      default: begin
        if (ctrl[gac_pkg::CTRL_TO]) begin
          next_state = ec_used ? gac_pkg::S_TO_DROP : gac_pkg::S_TO_LEAD;
        end else if (ctrl[gac_pkg::CTRL_CA]) begin
          next_state = (state == gac_pkg::S_CA_RUN) ? gac_pkg::S_CA_RUN : gac_pkg::S_CA_LEAD;
        end else if (ctrl[gac_pkg::CTRL_DISP]) begin
          next_state = gac_pkg::S_DISP;
        end else begin
          next_state = gac_pkg::S_IDLE;
        end
      end
    endcase
  end

  wire [W-1:0] load_val = (next_state == gac_pkg::S_TO_DROP)   ? TO_DROP[W-1:0]
                        : (next_state == gac_pkg::S_TO_SETTLE) ? EC_SETTLE[W-1:0]
                        : EC_LEAD[W-1:0];
  wire zero_req = ctrl[gac_pkg::CTRL_ZERO] | (zero_tmr != '0);
  wire ec_out   = (next_state == gac_pkg::S_DISP) || (next_state == gac_pkg::S_CA_RUN)
               || (next_state == gac_pkg::S_TO_SETTLE) || (next_state == gac_pkg::S_TO_RUN);
  wire ca_out   = (next_state == gac_pkg::S_CA_LEAD) || (next_state == gac_pkg::S_CA_RUN);
  wire to_out   = (next_state == gac_pkg::S_TO_LEAD) || (next_state == gac_pkg::S_TO_SETTLE)
               || (next_state == gac_pkg::S_TO_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= gac_pkg::S_IDLE;
      seq_tmr  <= '0;
      zero_tmr <= '0;
      disc     <= 4'h0;
    end else begin
      state    <= next_state;
      seq_tmr  <= (next_state != state) ? load_val - 1'b1 : (tmr_done ? seq_tmr : seq_tmr - 1'b1);
      zero_tmr <= (ctrl[gac_pkg::CTRL_ZERO] && !disc[0]) ? ZERO_MIN[W-1:0] - 1'b1
                : ((zero_tmr != '0) ? zero_tmr - 1'b1 : zero_tmr);
      disc     <= {to_out, ca_out, ec_out, zero_req};
    end
  end

  assign link.zero_n         = ~disc[0];
  assign link.ec_enable_n    = ~disc[1];
  assign link.coarse_align_n = ~disc[2];
  assign link.takeover_n     = ~disc[3];

  // ---------------------------------------------------------------
  // Commanded pulse sender and angle accumulator
  // ---------------------------------------------------------------
  logic [W-1:0] rate_tmr;
  logic [W-1:0] burst_tmr;
  logic [2:0]   up_q;
  logic [2:0]   dn_q;

  // Coarse align sends only inside the burst window; display and takeover run send steadily
  wire in_burst = burst_tmr < BURST_ON[W-1:0];
  wire send_ok  = (state == gac_pkg::S_TO_RUN) || (state == gac_pkg::S_DISP)
               || ((state == gac_pkg::S_CA_RUN) && in_burst);
  wire rate_hit = rate_tmr >= CMD_STEP[W-1:0] - 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_tmr  <= '0;
      burst_tmr <= '0;
    end else begin
      rate_tmr  <= rate_hit ? '0 : rate_tmr + 1'b1;
      burst_tmr <= (state != gac_pkg::S_CA_RUN || burst_tmr >= BURST_PER[W-1:0] - 1'b1)
                 ? '0 : burst_tmr + 1'b1;
    end
  end

  assign link.cmd_up = up_q;
  assign link.cmd_dn = dn_q;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      wire fire = send_ok && rate_hit && (pend[g] != 16'h0000);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend[g]  <= 16'h0000;
          up_q[g]  <= 1'b0;
          dn_q[g]  <= 1'b0;
          angle[g] <= 16'h0000;
        end else begin
          up_q[g] <= fire & ~pend[g][15];
          dn_q[g] <= fire & pend[g][15];
          if (wr && sel_cmd && cidx == g[1:0]) begin
            pend[g] <= pwdata[15:0];
          end else if (fire) begin
            pend[g] <= pend[g][15] ? pend[g] + 1'b1 : pend[g] - 1'b1;
          end
          if (link.angle_up[g] && !link.angle_dn[g]) begin
            angle[g] <= angle[g] + 1'b1;
          end else if (link.angle_dn[g] && !link.angle_up[g]) begin
            angle[g] <= angle[g] - 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule : gac_host

// file: test/gac_sva.sv
// Link checker: moding and pulse timing as seen on the discrete and pulse lines.
// Assumes the short host and device timing parameters that the bench sets.
`timescale 1ns/1ps
module gac_sva (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       zero_n,
  input wire logic       ec_enable_n,
  input wire logic       coarse_align_n,
  input wire logic       takeover_n,
  input wire logic [2:0] cmd_up,
  input wire logic [2:0] cmd_dn,
  input wire logic [2:0] angle_up,
  input wire logic [2:0] angle_dn
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [7:0] zero_len;
  wire        a0_pulse = angle_up[0] | angle_dn[0];
  wire        c0_pulse = cmd_up[0] | cmd_dn[0];
  wire        no_angle = (angle_up | angle_dn) == 3'h0;
  wire        no_cmd   = (cmd_up | cmd_dn) == 3'h0;

  // Saturates so that a long hold cannot wrap back under the minimum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_len <= 8'h00;
    end else if (zero_n) begin
      zero_len <= 8'h00;
    end else if (zero_len != 8'hff) begin
      zero_len <= zero_len + 8'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Six cycles leave room for the two-flop sync and a pulse in flight
  a_zero_blocks_steps: assert property ((!zero_n) [*6] |-> no_angle)
    else $error("angle pulse while counters held at zero");
  a_ca_blocks_steps: assert property (
    (!coarse_align_n && ec_enable_n) [*6] |-> no_angle)
    else $error("angle pulse in coarse align without enable");
  a_zero_min_hold: assert property ($rose(zero_n) |-> zero_len >= 8'h20)
    else $error("zero discrete released too early");
  a_to_after_drop: assert property (
    $fell(takeover_n) |-> ec_enable_n && $past(ec_enable_n, 40))
    else $error("takeover without enable dropped long enough");
  a_to_ec_lead: assert property (
    $fell(ec_enable_n) && !takeover_n |-> !$past(takeover_n, 50))
    else $error("enable too soon after takeover");
  a_to_settle_gap: assert property (
    $fell(ec_enable_n) && !takeover_n |-> no_cmd [*5])
    else $error("command pulse inside settle time");
  a_cmd_needs_ec: assert property (!no_cmd |-> !ec_enable_n)
    else $error("command pulse without enable");
  a_ca_ec_lead: assert property (
    $fell(ec_enable_n) && !coarse_align_n && takeover_n |-> !$past(coarse_align_n, 50))
    else $error("enable too soon after coarse align");
  a_cmd_rate_gap: assert property (c0_pulse |=> !c0_pulse [*7])
    else $error("command pulses closer than the send period");
  a_angle_rate_gap: assert property (a0_pulse |=> !a0_pulse [*3])
    else $error("angle pulses faster than coarse rate");
endmodule : gac_sva

// file: test/gimbal_angle_counter_moding_tb.sv
// Bench for both link ends: APB into the controller, resolver error into the unit.
// Assumes the short timing parameters set here; expectations derive from them.
`timescale 1ns/1ps
module gimbal_angle_counter_moding_tb;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } gac_row_s;
  logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]                   paddr;
  logic [31:0]                  pwdata, prdata, q;
  logic [2:0]                   eu, ed, eco, neg;
  logic [2:0][gac_pkg::RCW-1:0] ang;
  logic [2:0][gac_pkg::ECW-1:0] mag;
  logic                         crel, trel;
  logic [15:0]                  r0;
  int                           err_total = 0, checks = 0, d;
  gac_row_s rows [8] = '{'{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h14, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h30, 32'h5, 32'h0, 1'b1},
    '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}};

  gac_link_if gac_link_if_inst ();
  gac_device #(.COARSE_CYC(4)) gac_device_inst (.pclk(pclk), .presetn(presetn),
    .link(gac_link_if_inst.dev), .res_err_up(eu), .res_err_dn(ed), .res_err_coarse(eco),
    .read_angle(ang), .dac_mag(mag), .dac_neg(neg), .coarse_relay(crel), .takeover_relay(trel));
  gac_host #(.ZERO_MIN(32), .EC_LEAD(50), .CMD_STEP(8),
    .BURST_ON(30)) gac_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(gac_link_if_inst.host));
  gac_sva gac_sva_inst (.pclk(pclk), .presetn(presetn), .zero_n(gac_link_if_inst.zero_n),
    .ec_enable_n(gac_link_if_inst.ec_enable_n), .coarse_align_n(gac_link_if_inst.coarse_align_n),
    .takeover_n(gac_link_if_inst.takeover_n), .cmd_up(gac_link_if_inst.cmd_up),
    .cmd_dn(gac_link_if_inst.cmd_dn), .angle_up(gac_link_if_inst.angle_up),
    .angle_dn(gac_link_if_inst.angle_dn));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h to %h", $time, got, lo, hi);
    end
  endtask : chk_in

  task automatic print_verdict();
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Starts on a fresh edge so the release never shares a step with the next setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      print_verdict();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    eu      = 3'h7;
    ed      = 3'h7;
    eco     = 3'h7;
    cyc(20);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(q, rows[i].q);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    // Axis 0 climbs, axis 1 falls, axis 2 has no error
    eu <= 3'h5;
    ed <= 3'h6;
    cyc(80);
    chk_in({16'h0, ang[0]}, 32'h11, 32'h14);
    chk_in({16'h0, ang[1]}, 32'hffec, 32'hffef);
    eu  <= 3'h7;
    eco <= 3'h6;
    r0 = ang[0];
    cyc(640);
    chk_in({16'h0, ang[0] - r0}, 32'h8, 32'ha);
    ed <= 3'h7;
    cyc(6);
    apb(1'b0, gac_pkg::A_ANG0, 32'h0);
    chk(q, {16'h0, ang[0]});
    apb(1'b0, gac_pkg::A_ANG0 + 8'h04, 32'h0);
    chk(q, {16'h0, ang[1]});
    ed <= 3'h6;
    apb(1'b1, gac_pkg::A_CTRL, 32'h1);
    cyc(30);
    chk({ang[1], ang[0]}, 32'h0);
    apb(1'b0, gac_pkg::A_STATUS, 32'h0);
    chk({ang[0], q[15:0]}, 32'h1);
    ed <= 3'h7;
    apb(1'b1, gac_pkg::A_CTRL, 32'h0);
    cyc(25);
    apb(1'b1, gac_pkg::A_CTRL, 32'h4);
    cyc(10);
    apb(1'b1, gac_pkg::A_CMD0, 32'h3);
    apb(1'b1, gac_pkg::A_CMD0 + 8'h04, 32'hfffe);
    cyc(60);
    chk({mag[1], mag[0], 5'h0, neg}, {12'h2, 12'h3, 5'h0, 3'h2});
    apb(1'b0, gac_pkg::A_STATUS, 32'h0);
    chk(q, 32'h0000_0102);
    ed  <= 3'h6;
    eco <= 3'h7;
    cyc(40);
    ed <= 3'h7;
    cyc(6);
    chk({20'h0, mag[0]}, 32'h3);
    apb(1'b1, gac_pkg::A_CTRL, 32'h0);
    cyc(10);
    chk({mag[1], mag[0], 8'h0}, 32'h0);
    // Error stays present across the 20-cycle check inside the lead window, where stepping must stop
    ed <= 3'h6;
    apb(1'b1, gac_pkg::A_CTRL, 32'h2);
    cyc(5);
    chk({31'h0, crel}, 32'h1);
    r0 = ang[0];
    cyc(20);
    chk({16'h0, ang[0]}, {16'h0, r0});
    ed <= 3'h7;
    apb(1'b1, gac_pkg::A_CMD0, 32'h4);
    cyc(310);
    chk({20'h0, mag[0]}, 32'h4);
    r0 = ang[0];
    ed <= 3'h6;
    cyc(14);
    ed <= 3'h7;
    cyc(10);
    d = int'(ang[0] - r0);
    chk_in(d, 32'h2, 32'h5);
    chk({19'h0, neg[0], mag[0]},
        (d > 4) ? {19'h0, 1'b1, 12'(d - 4)} : {20'h0, 12'(4 - d)});
    apb(1'b1, gac_pkg::A_CTRL, 32'h8);
    cyc(110);
    chk({30'h0, trel, crel}, 32'h2);
    apb(1'b0, gac_pkg::A_STATUS, 32'h0);
    chk({q[31:12], mag[0]}, 32'h0000_0000);
    chk(q, 32'h0000_070a);
    presetn <= 1'b0;
    cyc(2);
    chk({ang[0], mag[0], crel, trel, gac_link_if_inst.zero_n, gac_link_if_inst.ec_enable_n},
        32'h0000_0003);
    presetn <= 1'b1;
    cyc(5);
    print_verdict();
  end
endmodule : gimbal_angle_counter_moding_tb
